// >>> hdl/dflr_regs.svh
// Offsets, field positions and codes of the fault latch block
`ifndef DFLR_REGS_SVH
`define DFLR_REGS_SVH
// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define DFLR_CTRL_OFS 12'h000
`define DFLR_STAT_OFS 12'h004
`define DFLR_CODE_OFS 12'h008
// ***********************************************************************
// Control register bits (write 1 acts; bit 4 holds the written level)
// ***********************************************************************
`define DFLR_CTRL_PA_ARM 0
`define DFLR_CTRL_PANEL_CLR 1
`define DFLR_CTRL_FSEEK_SET 2
`define DFLR_CTRL_SEEK_SET 3
`define DFLR_CTRL_WP_SWITCH 4
// ***********************************************************************
// Latch index in the latch vector
// ***********************************************************************
`define DFLR_L_VOLT 0
`define DFLR_L_OFFCYL 1
`define DFLR_L_WFAULT 2
`define DFLR_L_HSEL 3
`define DFLR_L_RDWR 4
`define DFLR_L_WPROT 5
`define DFLR_L_FSEEK 6
`define DFLR_L_SEEK 7
`define DFLR_NUM_FAULTS 7
`define DFLR_NUM_LATCH 8
// ***********************************************************************
// Status register fields above the latch byte
// ***********************************************************************
`define DFLR_STAT_FAULT 8
`define DFLR_STAT_PA 9
`define DFLR_STAT_PWP 10
`define DFLR_STAT_WEN 11
// ***********************************************************************
// SMD bus bits
// ***********************************************************************
`define DFLR_OUT_FCLR 4
`define DFLR_OUT_RTZ 6
`define DFLR_IN_SEEK 2
`define DFLR_IN_FAULT 3
// ***********************************************************************
// Error codes: no error, then latch index plus one
// ***********************************************************************
`define DFLR_CODE_NONE 8'h00
`define DFLR_CTRL_RST 5'h01
`endif

// >>> hdl/dflr_pkg.sv
// Types of the fault latch block
package dflr_pkg;
   typedef logic [7:0] dflr_byte_t;
   typedef logic [7:0] dflr_latch_t;
   typedef logic [7:0] dflr_code_t;
   typedef logic [1:0] dflr_chan_t;
endpackage

// >>> hdl/dflr_latch_cell.sv
// One sticky error latch with conditional clear
`timescale 1ns/1ps
module dflr_latch_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_cond,
   input wire logic clr_req,
   output logic q
);
   logic q_q;
   logic q_d;
   // Clear acts only once the set condition is gone; set wins
   assign q_d = set_cond | (q_q & ~clr_req);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end
   assign q = q_q;
endmodule // dflr_latch_cell

// >>> hdl/dflr_fault_latch.sv
// Fault and seek error latches with SMD, SCSI, IPI reporting and APB
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "dflr_regs.svh"
module dflr_fault_latch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic read_gate,
   input wire logic write_gate,
   input wire logic on_cylinder,
   input wire dflr_pkg::dflr_chan_t write_ok,
   input wire dflr_pkg::dflr_chan_t clock_fault,
   input wire dflr_pkg::dflr_chan_t write_select_verify,
   input wire dflr_pkg::dflr_byte_t arm_select_a,
   input wire dflr_pkg::dflr_byte_t arm_select_b,
   input wire logic voltage_low,
   input wire logic logic_supply_low,
   input wire logic write_protect_mode,
   input wire logic tag1,
   input wire logic tag2,
   input wire logic tag3,
   input wire logic tag5,
   input wire logic unit_select_tag,
   input wire dflr_pkg::dflr_byte_t bus_out,
   output dflr_pkg::dflr_byte_t bus_in,
   input wire logic request_sense,
   input wire logic rezero_unit,
   output logic check_condition,
   input wire logic read_status,
   input wire logic recalibrate,
   output logic status_pending,
   output logic exception_status,
   output logic attention_in,
   output dflr_pkg::dflr_code_t error_code,
   output logic fault,
   output logic write_enable,
   output logic pa_enable,
   output logic processor_write_protect,
   output logic processor_master_clear,
   output logic sector_counter_reset,
   output logic servo_reset,
   output logic motor_reset,
   output logic retract,
   output logic load_abort,
   output logic load_restart
);
   import dflr_pkg::*;

   // ********************************************************************
   // Functions
   // ********************************************************************
   function automatic logic multi_sel(input dflr_byte_t s);
      return (s & (s - 8'h01)) != 8'h00;
   endfunction

   function automatic dflr_code_t code_of(input dflr_latch_t l);
      dflr_code_t c;
      c = `DFLR_CODE_NONE;
      for (int i = `DFLR_NUM_LATCH - 1; i >= 0; i--) begin
         if (l[i]) begin
            c = 8'(i + 1);
         end
      end
      return c;
   endfunction

   // ********************************************************************
   // APB decode
   // ********************************************************************
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [4:0] ctrl_q;
   wire setup_ph = psel & ~penable;
   wire acc = psel & penable & pready_q;
   wire hit_ctrl = paddr == `DFLR_CTRL_OFS;
   wire hit_stat = paddr == `DFLR_STAT_OFS;
   wire hit_code = paddr == `DFLR_CODE_OFS;
   wire mapped = hit_ctrl | hit_stat | hit_code;
   wire wr_ctrl = acc & pwrite & hit_ctrl;
   wire arm_pa = wr_ctrl & pwdata[`DFLR_CTRL_PA_ARM];
   wire panel_clr = wr_ctrl & pwdata[`DFLR_CTRL_PANEL_CLR];
   wire fseek_set = wr_ctrl & pwdata[`DFLR_CTRL_FSEEK_SET];
   wire seek_set = wr_ctrl & pwdata[`DFLR_CTRL_SEEK_SET];

   // ********************************************************************
   // Latch set and clear terms
   // ********************************************************************
   dflr_latch_t latch;
   dflr_latch_t set_vec;
   dflr_latch_t clr_vec;
   logic pa_q;
   logic pwp_q;
   logic wen_q;
   wire protect = write_protect_mode | pwp_q;
   wire gates = read_gate | write_gate;
   wire [1:0] wf_chan = ~write_ok | (clock_fault & {2{write_gate}})
                        | ~write_select_verify;
   wire smd_fclr = tag3 & bus_out[`DFLR_OUT_FCLR];
   wire smd_rtz = tag3 & bus_out[`DFLR_OUT_RTZ];
   wire fault_clr = smd_fclr | request_sense | read_status
                    | panel_clr;
   wire seek_clr = smd_rtz | rezero_unit | recalibrate;

   assign set_vec[`DFLR_L_VOLT] = voltage_low;
   assign set_vec[`DFLR_L_OFFCYL] = gates
          & (~on_cylinder | latch[`DFLR_L_SEEK]);
   assign set_vec[`DFLR_L_WFAULT] = wen_q & (|wf_chan);
   assign set_vec[`DFLR_L_HSEL] = wen_q
          & (multi_sel(arm_select_a) | multi_sel(arm_select_b));
   assign set_vec[`DFLR_L_RDWR] = read_gate & write_gate;
   assign set_vec[`DFLR_L_WPROT] = write_gate & protect;
   assign set_vec[`DFLR_L_FSEEK] = fseek_set;
   assign set_vec[`DFLR_L_SEEK] = seek_set;
   assign clr_vec = {seek_clr, {`DFLR_NUM_FAULTS{fault_clr}}};

   // ********************************************************************
   // Latch bank
   // ********************************************************************
   genvar g;
   generate
      for (g = 0; g < `DFLR_NUM_LATCH; g++) begin : g_latch
         dflr_latch_cell u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .set_cond(set_vec[g]),
            .clr_req(clr_vec[g]),
            .q(latch[g])
         );
      end
   endgenerate

   // ********************************************************************
   // Derived status
   // ********************************************************************
   wire any_fault = |latch[`DFLR_NUM_FAULTS-1:0];
   wire any_err = |latch;
   wire smd_tag = tag1 | tag2 | tag3 | unit_select_tag;
   wire ext_req = tag5 & (bus_out == 8'h00);
   dflr_byte_t bus_in_d;
   assign bus_in_d = ext_req ? {1'b0, latch[`DFLR_NUM_FAULTS-1:0]}
                   : smd_tag ? {4'h0, any_fault, latch[`DFLR_L_SEEK],
                                2'b00}
                   : 8'h00;
   wire pa_d = ~(voltage_low | logic_supply_low)
               & (pa_q | arm_pa);
   wire pwp_d = ~pa_q | ctrl_q[`DFLR_CTRL_WP_SWITCH];
   wire wen_d = write_gate & ~protect & ~any_fault;
   wire fs_clr = latch[`DFLR_L_FSEEK] & ~set_vec[`DFLR_L_FSEEK]
                 & fault_clr;
   wire [31:0] stat_word = {20'h0_0000, wen_q, pwp_q, pa_q, any_fault,
                            latch};
   wire [31:0] rd_mux = hit_ctrl ? {27'h000_0000, ctrl_q}
                      : hit_stat ? stat_word
                      : hit_code ? {24'h00_0000, code_of(latch)}
                      : 32'h0000_0000;

   // ********************************************************************
   // APB slave flops
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup_ph;
         pslverr_q <= setup_ph & ~mapped;
         prdata_q <= (setup_ph & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 5'h00;
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[4:0];
      end
   end

   // ********************************************************************
   // Write path and power amp
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_q <= 1'b0;
         pwp_q <= 1'b1;
         wen_q <= 1'b0;
      end else begin
         pa_q <= pa_d;
         pwp_q <= pwp_d;
         wen_q <= wen_d;
      end
   end

   // ********************************************************************
   // Reporting flops
   // ********************************************************************
   dflr_byte_t bus_in_q;
   dflr_code_t code_q;
   logic fault_q;
   logic err_q;
   logic lvl_q;
   logic abort_q;
   logic restart_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_in_q <= 8'h00;
         code_q <= `DFLR_CODE_NONE;
         fault_q <= 1'b0;
         err_q <= 1'b0;
         lvl_q <= 1'b0;
         abort_q <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         bus_in_q <= bus_in_d;
         code_q <= code_of(latch);
         fault_q <= any_fault;
         err_q <= any_err;
         lvl_q <= logic_supply_low;
         abort_q <= latch[`DFLR_L_FSEEK];
         restart_q <= fs_clr;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign bus_in = bus_in_q;
   assign check_condition = err_q;
   assign status_pending = err_q;
   assign exception_status = err_q;
   assign attention_in = err_q;
   assign error_code = code_q;
   assign fault = fault_q;
   assign write_enable = wen_q;
   assign pa_enable = pa_q;
   assign processor_write_protect = pwp_q;
   assign processor_master_clear = lvl_q;
   assign sector_counter_reset = lvl_q;
   assign servo_reset = lvl_q;
   assign motor_reset = lvl_q;
   assign retract = lvl_q;
   assign load_abort = abort_q;
   assign load_restart = restart_q;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fault_or_latches: assert property (
      ##1 fault == $past(|latch[6:0]))
      else $error("fault line not OR of seven latches");
   a_smd_fault_bit: assert property (
      smd_tag && !ext_req |=> bus_in[3] == $past(any_fault))
      else $error("bus in bit 3 wrong");
   a_smd_seek_bit: assert property (
      smd_tag && !ext_req |=> bus_in[2] == $past(latch[7]))
      else $error("bus in bit 2 wrong");
   a_ext_status: assert property (
      ext_req |=> bus_in == {1'b0, $past(latch[6:0])})
      else $error("extended status wrong");
   a_clear_kept: assert property (
      fault_clr && set_vec[0] |=> latch[0])
      else $error("latch cleared while condition held");
   a_clear_works: assert property (
      fault_clr && !set_vec[1] |=> !latch[1])
      else $error("fault clear ineffective");
   a_seek_sticky: assert property (
      latch[7] && !seek_clr |=> latch[7])
      else $error("seek error lost without rezero");
   a_seek_clear: assert property (
      seek_clr && !seek_set |=> !latch[7])
      else $error("seek error not cleared");
   a_check_cond: assert property (
      any_err |=> check_condition && attention_in && status_pending)
      else $error("error not reported");
   a_offcyl_set: assert property (
      write_gate && !on_cylinder |=> latch[1])
      else $error("off cylinder access not latched");
   a_rdwr_set: assert property (
      read_gate && write_gate |=> latch[4] ##1 fault)
      else $error("read and write fault missing");
   a_wprot_block: assert property (
      write_gate && protect |=> !write_enable && latch[5])
      else $error("protected write not blocked");
   a_volt_pa: assert property (
      voltage_low |=> !pa_enable ##1 processor_write_protect)
      else $error("undervoltage did not drop amp");
   a_vcc_low: assert property (
      logic_supply_low |=> processor_master_clear && retract
                            ##0 !pa_enable)
      else $error("logic supply low not handled");
   a_wf_gated: assert property (
      !wen_q |=> $stable(latch[2]) || !latch[2])
      else $error("write fault set outside write enable");
   a_apb_ready: assert property (
      setup_ph |=> pready ##1 !pready)
      else $error("apb ready timing wrong");

   c_smd_clear: cover property (latch[1] ##1 smd_fclr ##1 !latch[1]);
   c_rtz: cover property (latch[7] ##1 smd_rtz ##1 !latch[7]);
   c_restart: cover property (load_abort ##[1:20] load_restart);
   c_apb_rd: cover property (acc && !pwrite && hit_stat);
endmodule // dflr_fault_latch

// >>> verif/dflr_host_model.sv
// Host controller model: SMD tags and bus, SCSI and IPI command pulses
`timescale 1ns/1ps
module dflr_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] cmd,
   output logic tag1,
   output logic tag2,
   output logic tag3,
   output logic tag5,
   output logic unit_select_tag,
   output dflr_pkg::dflr_byte_t bus_out,
   output logic request_sense,
   output logic rezero_unit,
   output logic read_status,
   output logic recalibrate
);
   import dflr_pkg::*;
   // ******************************************************************
   // Commands: 1-4 status tags, 5 extended status, 6 tag 5 with bus 20, 7 fault clear,
   // 8 return to zero, 9 sense, a rezero, b read status, c recalibrate
   // ******************************************************************
   dflr_byte_t bus_d;
   // Released bus shows a pattern that changes every cycle
   assign bus_d = (cmd == 4'h6) ? 8'h20 :
                  (cmd == 4'h7) ? 8'h10 :
                  (cmd == 4'h8) ? 8'h40 :
                  (cmd == 4'h3 || cmd == 4'h5) ? 8'h00 : ~bus_out;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tag1, tag2, tag3, tag5, unit_select_tag} <= 5'h00;
         {request_sense, rezero_unit, read_status, recalibrate} <= 4'h0;
         bus_out <= 8'h00;
      end else begin
         tag1 <= cmd == 4'h1;
         tag2 <= cmd == 4'h2;
         tag3 <= cmd == 4'h3 || cmd == 4'h7 || cmd == 4'h8;
         unit_select_tag <= cmd == 4'h4;
         tag5 <= cmd == 4'h5 || cmd == 4'h6;
         request_sense <= cmd == 4'h9;
         rezero_unit <= cmd == 4'ha;
         read_status <= cmd == 4'hb;
         recalibrate <= cmd == 4'hc;
         bus_out <= bus_d;
      end
   end
endmodule // dflr_host_model

// >>> verif/test_drive_fault_latch_reporting.sv
// Self-checking bench of the fault latch block with a behavioural model
`timescale 1ns/1ps
`include "dflr_regs.svh"
module test_drive_fault_latch_reporting;
   import dflr_pkg::*;
   localparam logic [11:0] ctl_a = `DFLR_CTRL_OFS;
   localparam logic [11:0] sta_a = `DFLR_STAT_OFS;
   localparam logic [11:0] cod_a = `DFLR_CODE_OFS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic read_gate, write_gate, on_cylinder, voltage_low, logic_supply_low;
   logic write_protect_mode, tag1, tag2, tag3, tag5, unit_select_tag;
   logic request_sense, rezero_unit, read_status, recalibrate;
   logic check_condition, status_pending, exception_status, attention_in;
   logic fault, write_enable, pa_enable, processor_write_protect;
   logic processor_master_clear, sector_counter_reset, servo_reset;
   logic motor_reset, retract, load_abort, load_restart;
   dflr_chan_t write_ok, clock_fault, write_select_verify;
   dflr_byte_t arm_select_a, arm_select_b, bus_out, bus_in;
   dflr_code_t error_code;
   logic [3:0] cmd;
   int errors, n_checks, exp_lat;
   dflr_fault_latch DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .read_gate, .write_gate, .on_cylinder, .write_ok,
      .clock_fault, .write_select_verify, .arm_select_a, .arm_select_b,
      .voltage_low, .logic_supply_low, .write_protect_mode, .tag1, .tag2,
      .tag3, .tag5, .unit_select_tag, .bus_out, .bus_in, .request_sense,
      .rezero_unit, .check_condition, .read_status, .recalibrate,
      .status_pending, .exception_status, .attention_in, .error_code,
      .fault, .write_enable, .pa_enable, .processor_write_protect,
      .processor_master_clear, .sector_counter_reset, .servo_reset,
      .motor_reset, .retract, .load_abort, .load_restart
   );
   dflr_host_model host_i (
      .pclk, .presetn, .cmd, .tag1, .tag2, .tag3, .tag5, .unit_select_tag,
      .bus_out, .request_sense, .rezero_unit, .read_status, .recalibrate
   );
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ******************************************************************
   // Shared tasks
   // ******************************************************************
   task automatic end_of_test();
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask
   task automatic host(input logic [3:0] c, output dflr_byte_t b);
      @(posedge pclk);
      cmd <= c;
      @(posedge pclk);
      cmd <= 4'h0;
      @(posedge pclk);
      #1 b = bus_in;
   endtask
   function automatic int code_of(input int l);
      for (int i = 0; i < 8; i++)
         if (l[i]) return i + 1;
      return 0;
   endfunction
   task automatic stat_chk(input logic p);
      logic [31:0] r;
      logic e, f, a;
      dflr_byte_t b;
      f = exp_lat[6:0] != 0;
      a = exp_lat != 0;
      apb(1'b0, sta_a, 32'h0, r, e);
      chk({21'h0, r[10:0]}, {21'h0, !p, p, f, exp_lat[7:0]});
      apb(1'b0, cod_a, 32'h0, r, e);
      chk(r, code_of(exp_lat));
      chk({fault, check_condition, status_pending, exception_status,
           attention_in, pa_enable, processor_write_protect, error_code},
          {f, {4{a}}, p, !p, 8'(code_of(exp_lat))});
      host(4'(1 + $urandom % 4), b);
      chk(b, {4'h0, f, exp_lat[7], 2'h0});
      host(4'h5, b);
      chk(b, {1'b0, exp_lat[6:0]});
      host(4'h6, b);
      chk(b, 8'h00);
   endtask
   task automatic arm();
      logic [31:0] r;
      logic e;
      apb(1'b1, ctl_a, 32'h1, r, e);
      repeat (2) @(posedge pclk);
   endtask
   task automatic cond(input int i, input logic v);
      int k;
      @(posedge pclk);
      case (i)
         0: voltage_low <= v;
         1: begin
            on_cylinder <= !v;
            read_gate <= v;
         end
         2: begin
            // One of the three write fault sources, picked at random
            write_gate <= v;
            k = v ? $urandom % 3 : 3;
            write_ok <= k == 0 ? 2'h1 : 2'h3;
            clock_fault <= k == 1 ? 2'h2 : 2'h0;
            write_select_verify <= k == 2 ? 2'h2 : 2'h3;
         end
         3: begin
            write_gate <= v;
            k = $urandom % 2;
            arm_select_a <= v && k == 0 ? 8'h03 : 8'h01;
            arm_select_b <= v && k == 1 ? 8'h0c : 8'h00;
         end
         4: {read_gate, write_gate} <= {v, v};
         default: {write_protect_mode, write_gate} <= {v, v};
      endcase
   endtask
   task automatic clr(input int m);
      logic [31:0] r;
      logic e;
      dflr_byte_t b;
      case (m)
         0: host(4'h7, b);
         1: host(4'h9, b);
         2: host(4'hb, b);
         default: apb(1'b1, ctl_a, 32'h2, r, e);
      endcase
      repeat (3) @(posedge pclk);
   endtask
   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial begin
      logic [31:0] r;
      logic e;
      dflr_byte_t b;
      int k;
      {psel, penable, pwrite, read_gate, write_gate, voltage_low} = 6'h00;
      {logic_supply_low, write_protect_mode, presetn} = 3'h0;
      {paddr, pwdata, cmd, arm_select_b} = 56'h0;
      on_cylinder = 1'b1;
      write_ok = 2'h3;
      clock_fault = 2'h0;
      write_select_verify = 2'h3;
      arm_select_a = 8'h01;
      exp_lat = 0;
      void'($urandom(33));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ctl_a, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b1, 12'h00c, 32'hffff_ffff, r, e);
      chk(e, 1'b1);
      apb(1'b0, 12'h00c, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b1, sta_a, 32'hffff_ffff, r, e);
      stat_chk(1'b0);
      arm();
      @(posedge pclk);
      write_gate <= 1'b1;
      arm_select_a <= 8'h01 << ($urandom % 8);
      repeat (4) @(posedge pclk);
      apb(1'b0, sta_a, 32'h0, r, e);
      chk(r[11:0], 12'ha00);
      chk(write_enable, 1'b1);
      @(posedge pclk);
      write_gate <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         arm();
         cond(i, 1'b1);
         repeat (4) @(posedge pclk);
         exp_lat = 1 << i;
         if (i == 5) begin
            apb(1'b0, sta_a, 32'h0, r, e);
            chk(r[11], 1'b0);
         end
         stat_chk(i != 0);
         if (i == 0 || i == 1 || i == 4) begin
            clr(i % 4);
            stat_chk(i != 0);
         end
         cond(i, 1'b0);
         repeat (3) @(posedge pclk);
         clr(i % 4);
         exp_lat = 0;
         stat_chk(i != 0);
      end
      // Write gate while off cylinder
      arm();
      @(posedge pclk);
      on_cylinder <= 1'b0;
      write_gate <= 1'b1;
      repeat (4) @(posedge pclk);
      exp_lat = 2;
      stat_chk(1'b1);
      @(posedge pclk);
      on_cylinder <= 1'b1;
      write_gate <= 1'b0;
      clr(3);
      exp_lat = 0;
      stat_chk(1'b1);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, ctl_a, 32'h8, r, e);
         repeat (3) @(posedge pclk);
         exp_lat = 128;
         stat_chk(1'b1);
         clr(0);
         stat_chk(1'b1);
         host(4'(8 + 2 * m), b);
         repeat (3) @(posedge pclk);
         exp_lat = 0;
         stat_chk(1'b1);
      end
      // Protect switch forces processor write protect with amp on
      apb(1'b1, ctl_a, 32'h11, r, e);
      repeat (2) @(posedge pclk);
      apb(1'b0, sta_a, 32'h0, r, e);
      chk(r[10:9], 2'h3);
      apb(1'b1, ctl_a, 32'h4, r, e);
      repeat (3) @(posedge pclk);
      exp_lat = 64;
      stat_chk(1'b1);
      chk(load_abort, 1'b1);
      apb(1'b1, ctl_a, 32'h2, r, e);
      k = 0;
      for (int j = 0; j < 6; j++) begin
         @(posedge pclk);
         if (load_restart === 1'b1) k++;
      end
      chk(k, 1);
      exp_lat = 0;
      stat_chk(1'b1);
      chk(load_abort, 1'b0);
      logic_supply_low <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({processor_master_clear, sector_counter_reset, servo_reset,
           motor_reset, retract, pa_enable}, 6'h3e);
      logic_supply_low <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({processor_master_clear, sector_counter_reset, servo_reset,
           motor_reset, retract}, 5'h00);
      end_of_test();
   end
   initial begin
      #200000;
      errors++;
      end_of_test();
   end
endmodule // test_drive_fault_latch_reporting
